// >>> inc/sat_pkg.sv
// constants, commands and carrier types of the segment address translator
package sat_pkg;
  localparam int SEL_W = 16;
  localparam int OFF_W = 16;
  localparam int PA_W = 24;
  localparam int RA_W = 20;
  localparam int IDX_W = 13;
  localparam int SEG_N = 4;
  localparam int MEM_W = 64;
  // selector layout: rpl in 1:0, table pick in 2, index in 15:3
  localparam int SEL_TI_BIT = 2;
  localparam int SEL_IDX_LSB = 3;
  // global table may not be indexed above this entry
  localparam logic [IDX_W-1:0] GDT_IDX_MAX = 13'h00ff;
  // access byte: present flag and privilege level field
  localparam int ACC_PRES_BIT = 7;
  localparam int ACC_DPL_LSB = 5;
  // descriptor fields inside the fetched 64-bit entry
  localparam int MEM_LIM_LSB = 0;
  localparam int MEM_BASE_LSB = 16;
  localparam int MEM_ACC_LSB = 40;
  // cache contents built for a real-mode segment load, then reset values of table base and selectors
  localparam logic [7:0] REAL_ACC = 8'h80;
  localparam logic [15:0] REAL_LIMIT = 16'hffff;
  localparam logic [PA_W-1:0] RST_GDT_BASE = 24'h00_0000;
  localparam logic [SEL_W-1:0] RST_SEL = 16'h0000;

  typedef enum logic [2:0] {
    CMD_XLATE = 3'b000,
    CMD_XLATE_SEG = 3'b001,
    CMD_PHYS = 3'b010,
    CMD_LOAD_SEG = 3'b011,
    CMD_LOAD_LDT = 3'b100,
    CMD_LOAD_GDT = 3'b101
  } sat_cmd_e;

  typedef enum logic [1:0] {
    FLT_NONE = 2'b00,
    FLT_RANGE = 2'b01,
    FLT_ABSENT = 2'b10,
    FLT_LIMIT = 2'b11
  } sat_fault_e;

  // 48-bit descriptor cache
  typedef struct packed {
    logic [7:0] access;
    logic [PA_W-1:0] base;
    logic [15:0] limit;
  } sat_desc_s;

  typedef struct packed {
    sat_cmd_e cmd;
    logic [1:0] seg;
    logic [SEL_W-1:0] selector;
    logic [OFF_W-1:0] offset;
    logic [PA_W-1:0] phys;
  } sat_req_s;
endpackage

// >>> testbench/sat_mem_model.sv
// memory model answering descriptor fetches of the translator
`timescale 1ns/1ps
module sat_mem_model
  import sat_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic mem_req_in,
  input wire logic [PA_W-1:0] mem_addr_in,
  output logic mem_ack_out,
  output logic [MEM_W-1:0] mem_data_out
);
  logic [MEM_W-1:0] last = '0;
  int cnt = 0;
  initial
  begin
    mem_ack_out = 0;
    mem_data_out = '1;
  end
  // answer after 0..3 extra cycles picked from address bits 4:3
  always @(posedge sys_clk_in)
  begin
    #1;
    mem_ack_out = 0;
    mem_data_out = ~last; // released bus never shows the old entry
    if (mem_req_in && cnt >= mem_addr_in[4:3])
    begin
      // entry: present unless addr bit 6, level from bits 4:3
      last = {16'h0000, ~mem_addr_in[6], mem_addr_in[4:3], 5'h00,
              mem_addr_in + 24'h01_0000, 16'h8000};
      mem_data_out = last;
      mem_ack_out = 1;
      cnt = 0;
    end
    else
      cnt = mem_req_in ? cnt + 1 : 0;
  end
endmodule

// >>> testbench/sat_translator_test.sv
// self-checking bench for the segment address translator
`timescale 1ns/1ps
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin \
  fail_count++; $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module sat_translator_test
  import sat_pkg::*;
;
  typedef struct packed {
    logic [1:0] chk;
    logic [1:0] descriptor_privilege_level;
    sat_fault_e f;
    logic [PA_W-1:0] pa;
  } sat_note_s;
  localparam sat_note_s LD = '{2'd0, 2'd0, FLT_NONE, 24'h00_0000};
  logic sys_clk_in = 0, rstn_in = 0, emulating_in = 1, prot_mode_in = 0;
  logic translation_select_flag_in = 0, req_valid_in = 0, mreq_d = 0;
  logic busy_out, done_out, mem_req_out, mem_ack_in;
  sat_req_s req_in = '0;
  sat_fault_e fault_out;
  logic [PA_W-1:0] phys_out, mem_addr_out, a, ea;
  logic [PA_W-1:0] gbase = 24'h10_0000;
  logic [1:0] dpl_out;
  logic [MEM_W-1:0] mem_data_in;
  logic [15:0] s, o;
  sat_note_s q[$], n;
  logic [PA_W-1:0] aq[$];
  int fail_count = 0, compares = 0, seed = 10;
  int ix[7] = '{0, 1, 2, 3, 9, 255, 2};
  sat_translator i_sat_translator (.sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in), .emulating_in(emulating_in),
    .prot_mode_in(prot_mode_in),
    .translation_select_flag_in(translation_select_flag_in),
    .req_valid_in(req_valid_in), .req_in(req_in), .busy_out(busy_out),
    .done_out(done_out), .fault_out(fault_out), .phys_out(phys_out),
    .dpl_out(dpl_out), .mem_req_out(mem_req_out),
    .mem_addr_out(mem_addr_out), .mem_ack_in(mem_ack_in),
    .mem_data_in(mem_data_in));
  sat_mem_model i_sat_mem_model (.sys_clk_in(sys_clk_in),
    .mem_req_in(mem_req_out), .mem_addr_in(mem_addr_out),
    .mem_ack_out(mem_ack_in), .mem_data_out(mem_data_in));
  // 25 MHz clock
  initial
  begin
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  // expected result of a descriptor entry fetched from address x
  function automatic sat_note_s pn(logic [PA_W-1:0] x, logic [15:0] of);
    pn.pa = x + 24'h01_0000 + of;
    pn.descriptor_privilege_level = x[4:3];
    pn.f = x[6] ? FLT_ABSENT : (of > 16'h8000 ? FLT_LIMIT : FLT_NONE);
    pn.chk = (pn.f == FLT_NONE) ? 2'd2 : 2'd0;
  endfunction
  task automatic issue(sat_cmd_e c, logic [1:0] sg, logic [15:0] sl, of,
                       logic [PA_W-1:0] p, sat_note_s e);
    req_in = '{c, sg, sl, of, p};
    req_valid_in = 1;
    q.push_back(e);
    @(posedge sys_clk_in);
    #1;
  endtask
  task automatic drain;
    req_valid_in = 0;
    for (int k = 0; k < 60 && q.size() > 0; k++) @(posedge sys_clk_in);
    @(posedge sys_clk_in);
    #1;
  endtask
  task automatic fetch(sat_cmd_e c, logic [1:0] sg, logic [15:0] sl, of,
                       logic [PA_W-1:0] x, sat_note_s e);
    aq.push_back(x);
    issue(c, sg, sl, of, 0, e);
    drain();
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // watch fetch addresses and answers against the notes
  always @(negedge sys_clk_in)
  begin
    mreq_d <= mem_req_out;
    if (mem_req_out === 1'b1 && mreq_d !== 1'b1)
    begin
      ea = aq.size() ? aq.pop_front() : 24'hff_ffff;
      `CHK("fetch addr", ea, mem_addr_out)
      `CHK("busy", 1'b1, busy_out)
    end
    if (done_out === 1'b1)
    begin
      n = q.size() ? q.pop_front() : '1;
      `CHK("fault", n.f, fault_out)
      `CHK("idle", 1'b0, busy_out)
      if (n.chk != 0) `CHK("phys", n.pa, phys_out)
      if (n.chk == 2) `CHK("dpl", n.descriptor_privilege_level, dpl_out)
    end
  end
  // watchdog
  initial
  begin
    repeat (5000) @(posedge sys_clk_in);
    fail_count++;
    conclude();
  end
  // scenarios
  initial
  begin
    repeat (20) @(posedge sys_clk_in);
    #1;
    rstn_in = 1;
    for (int k = 0; k < 9; k++)
    begin
      s = k ? 16'($random(seed)) : 16'hffff;
      o = k ? 16'($random(seed)) : 16'hffff;
      issue(CMD_XLATE, 0, s, o, 0,
            '{1, 0, FLT_NONE, {4'h0, 20'({s, 4'h0} + o)}});
    end
    a = 24'($random(seed));
    issue(CMD_PHYS, 0, 0, 0, a, '{1, 0, FLT_NONE, a});
    drain();
    emulating_in = 0;
    issue(CMD_XLATE, 0, 16'h1234, 16'h0010, 0,
          '{1, 0, FLT_NONE, 24'h01_2350});
    issue(CMD_LOAD_SEG, 1, 16'h2000, 0, 0, LD);
    issue(CMD_XLATE_SEG, 1, 0, 16'h0100, 0,
          '{1, 0, FLT_NONE, 24'h02_0100});
    drain();
    $display("real test done");
    translation_select_flag_in = 1;
    issue(CMD_LOAD_GDT, 0, 0, 0, gbase, LD);
    drain();
    foreach (ix[k])
    begin
      a = gbase + 24'(ix[k] * 8);
      o = (k == 6) ? 16'h8001 : 16'($random(seed)) & 16'h7fff;
      fetch(CMD_XLATE, 0, {13'(ix[k]), 1'b0, 2'(k)}, o, a, pn(a, o));
    end
    emulating_in = 1;
    prot_mode_in = 1;
    issue(CMD_XLATE, 0, {13'd256, 3'b000}, 0, 0,
          '{0, 0, FLT_RANGE, 0});
    issue(CMD_LOAD_LDT, 0, {13'd256, 3'b100}, 0, 0,
          '{0, 0, FLT_RANGE, 0});
    drain();
    $display("global test done");
    a = gbase + 24'd40;
    fetch(CMD_LOAD_LDT, 0, {13'd5, 3'b000}, 0, a, LD);
    a = a + 24'h01_0000 + 24'd2400;
    fetch(CMD_XLATE, 0, {13'd300, 3'b100}, 16'h0042, a,
          pn(a, 16'h0042));
    $display("local test done");
    a = gbase + 24'd48;
    fetch(CMD_LOAD_SEG, 2, {13'd6, 3'b000}, 0, a, LD);
    issue(CMD_XLATE_SEG, 2, 0, 16'h0007, 0, pn(a, 16'h0007));
    issue(CMD_XLATE_SEG, 2, 0, 16'h8000, 0, pn(a, 16'h8000));
    issue(CMD_XLATE_SEG, 2, 0, 16'h8001, 0, pn(a, 16'h8001));
    issue(CMD_XLATE_SEG, 3, 0, 16'h0000, 0,
          '{0, 0, FLT_ABSENT, 0});
    drain();
    $display("segment test done");
    conclude();
  end
endmodule

// >>> verilog/sat_translator.sv
// segment address translator: real and descriptor-based translation
`timescale 1ns/1ps
// Overview of operation
// RULE1 - while emulating, real mode uses real translation, protected uses descriptors.
// RULE2 - when not emulating, the translation select flag picks the method.
// RULE3 - real translation shifts the selector left four bits and adds the offset.
// RULE4 - a direct physical address takes 24 bits; a pointer still gives 20 bits.
// RULE5 - in protected mode 14 selector bits address and two bits protect.
// RULE6 - one selector bit picks global or local table, 13 bits index it.
// RULE7 - a descriptor gives access, base and limit; address is base plus offset.
// RULE8 - protected physical addresses are 24 bits wide.
// RULE9 - a global table index above 255 is refused as out of range.
// RULE10 - the global table register holds the base of the global table.
// RULE11 - the local table selector always indexes the global table.
// RULE12 - loading the local table selector also loads its 48-bit cache; a real-mode CMD_LOAD_LDT sets only ldt_sel.
// RULE13 - four segment registers hold selector and cache; use needs no fetch.
// RULE14 - an access bit marks the segment present in physical memory.
// RULE15 - two access bits give the privilege level, 0 highest, 3 lowest.
// RULE16 - the fetch address is table base plus index times eight.
module sat_translator
  import sat_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic emulating_in,
  input wire logic prot_mode_in,
  input wire logic translation_select_flag_in,
  input wire logic req_valid_in,
  input wire sat_req_s req_in,
  output logic busy_out,
  output logic done_out,
  output sat_fault_e fault_out,
  output logic [PA_W-1:0] phys_out,
  output logic [1:0] dpl_out,
  output logic mem_req_out,
  output logic [PA_W-1:0] mem_addr_out,
  input wire logic mem_ack_in,
  input wire logic [MEM_W-1:0] mem_data_in
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01
  } sat_state_e;

  // real-mode address: selector times sixteen plus offset
  function automatic logic [RA_W-1:0] real_addr(
    input logic [SEL_W-1:0] sel,
    input logic [OFF_W-1:0] off
  );
    real_addr = {sel, 4'h0} + {4'h0, off}; // see RULE3
  endfunction

  // split a fetched table entry into its cached fields
  function automatic sat_desc_s desc_of(input logic [MEM_W-1:0] d);
    desc_of.limit = d[MEM_LIM_LSB +: 16];
    desc_of.base = d[MEM_BASE_LSB +: PA_W]; // see RULE7
    desc_of.access = d[MEM_ACC_LSB +: 8];
  endfunction

  sat_state_e state;
  sat_req_s cur;
  logic cur_prot;
  logic [PA_W-1:0] gdt_base;
  logic [SEL_W-1:0] ldt_sel;
  sat_desc_s ldt_cache;
  logic [SEL_W-1:0] seg_sel [SEG_N];
  sat_desc_s seg_cache [SEG_N];

  // method choice for the incoming request
  wire in_prot = emulating_in ? prot_mode_in
                              : translation_select_flag_in; // see RULE1 RULE2

  // selector decode: table pick and index, rpl ignored here
  wire in_ldt_tbl = (req_in.cmd != CMD_LOAD_LDT)
                    && req_in.selector[SEL_TI_BIT]; // see RULE6 RULE11
  wire [IDX_W-1:0] in_idx = req_in.selector[SEL_W-1:SEL_IDX_LSB]; // see RULE5
  wire in_range_bad = !in_ldt_tbl && (in_idx > GDT_IDX_MAX); // see RULE9
  wire [PA_W-1:0] in_tbl_base = in_ldt_tbl ? ldt_cache.base
                                           : gdt_base; // see RULE10
  wire [PA_W-1:0] in_fetch_addr = in_tbl_base
                                  + {8'h00, in_idx, 3'b000}; // see RULE16
  wire in_needs_fetch = in_prot && (req_in.cmd == CMD_XLATE
                        || req_in.cmd == CMD_LOAD_SEG
                        || req_in.cmd == CMD_LOAD_LDT);

  // cached segment selected by the request
  sat_desc_s sc;
  assign sc = seg_cache[req_in.seg];
  wire [SEL_W-1:0] ss = seg_sel[req_in.seg];
  wire sc_absent = !sc.access[ACC_PRES_BIT];
  wire sc_over = req_in.offset > sc.limit;
  wire [PA_W-1:0] sc_sum = sc.base + {8'h00, req_in.offset}; // see RULE13
  wire [RA_W-1:0] in_real = real_addr(req_in.selector, req_in.offset);
  wire [RA_W-1:0] ss_real = real_addr(ss, req_in.offset);

  // descriptor arriving from memory
  sat_desc_s fd;
  assign fd = desc_of(mem_data_in);
  wire f_absent = !fd.access[ACC_PRES_BIT]; // see RULE14
  wire f_over = cur.offset > fd.limit;
  wire [PA_W-1:0] f_sum = fd.base + {8'h00, cur.offset}; // see RULE7 RULE8

  // cache image for a real-mode segment load
  sat_desc_s real_desc;
  assign real_desc = '{access: REAL_ACC,
                       base: {4'h0, req_in.selector, 4'h0},
                       limit: REAL_LIMIT};

  // request sequencing, table fetch and register updates
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state <= ST_IDLE;
      cur <= '0;
      cur_prot <= 1'b0;
      gdt_base <= RST_GDT_BASE;
      ldt_sel <= RST_SEL;
      ldt_cache <= '0;
      for (int i = 0; i < SEG_N; i++)
      begin
        seg_sel[i] <= RST_SEL;
        seg_cache[i] <= '0;
      end
      busy_out <= 1'b0;
      done_out <= 1'b0;
      fault_out <= FLT_NONE;
      phys_out <= '0;
      dpl_out <= 2'b00;
      mem_req_out <= 1'b0;
      mem_addr_out <= '0;
    end
    else
    begin
      done_out <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (req_valid_in)
          begin
            cur <= req_in;
            cur_prot <= in_prot;
            fault_out <= FLT_NONE;
            if (in_needs_fetch && in_range_bad)
            begin
              done_out <= 1'b1;
              fault_out <= FLT_RANGE; // see RULE9
            end
            else if (in_needs_fetch)
            begin
              state <= ST_FETCH;
              busy_out <= 1'b1;
              mem_req_out <= 1'b1;
              mem_addr_out <= in_fetch_addr; // see RULE16
            end
            else
            begin
              done_out <= 1'b1;
              case (req_in.cmd)
                CMD_XLATE:
                  phys_out <= {4'h0, in_real}; // see RULE3
                CMD_XLATE_SEG:
                begin
                  if (!in_prot)
                    phys_out <= {4'h0, ss_real}; // see RULE1 RULE3
                  else if (sc_absent)
                    fault_out <= FLT_ABSENT; // see RULE14
                  else if (sc_over)
                    fault_out <= FLT_LIMIT;
                  else
                  begin
                    phys_out <= sc_sum; // see RULE13
                    dpl_out <= sc.access[ACC_DPL_LSB +: 2]; // see RULE15
                  end
                end
                CMD_PHYS:
                  phys_out <= req_in.phys; // see RULE4
                CMD_LOAD_SEG:
                begin
                  seg_sel[req_in.seg] <= req_in.selector;
                  seg_cache[req_in.seg] <= real_desc;
                end
                CMD_LOAD_LDT:
                  ldt_sel <= req_in.selector;
                CMD_LOAD_GDT:
                  gdt_base <= req_in.phys; // see RULE10
                default:
                  fault_out <= FLT_NONE;
              endcase
            end
          end
        end
        ST_FETCH:
        begin
          if (mem_ack_in)
          begin
            state <= ST_IDLE;
            busy_out <= 1'b0;
            mem_req_out <= 1'b0;
            done_out <= 1'b1;
            if (f_absent)
              fault_out <= FLT_ABSENT; // see RULE14
            else
            begin
              case (cur.cmd)
                CMD_XLATE:
                begin
                  if (f_over)
                    fault_out <= FLT_LIMIT;
                  else
                  begin
                    phys_out <= f_sum; // see RULE7 RULE8
                    dpl_out <= fd.access[ACC_DPL_LSB +: 2]; // see RULE15
                  end
                end
                CMD_LOAD_SEG:
                begin
                  seg_sel[cur.seg] <= cur.selector; // see RULE13
                  seg_cache[cur.seg] <= fd;
                end
                CMD_LOAD_LDT:
                begin
                  ldt_sel <= cur.selector; // see RULE12
                  ldt_cache <= fd;
                end
                default:
                  fault_out <= FLT_NONE;
              endcase
            end
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // real pointer result is the 20-bit shift-and-add
  chk_real_shift_add: assert property ( // see RULE3
    @(posedge sys_clk_in) disable iff (!rstn_in)
    done_out && cur.cmd == CMD_XLATE && !cur_prot
    |-> phys_out == {4'h0, real_addr(cur.selector, cur.offset)})
    else $error("real translation result wrong");

  // method follows emulation mode or the select flag
  chk_mode_select: assert property ( // see RULE1 RULE2
    @(posedge sys_clk_in) disable iff (!rstn_in)
    state == ST_IDLE && req_valid_in && req_in.cmd == CMD_XLATE
    && !(emulating_in ? prot_mode_in : translation_select_flag_in)
    |=> done_out && !mem_req_out)
    else $error("real request started a table fetch");

  // a direct physical address passes with all 24 bits
  chk_phys_pass: assert property ( // see RULE4
    @(posedge sys_clk_in) disable iff (!rstn_in)
    state == ST_IDLE && req_valid_in && req_in.cmd == CMD_PHYS
    |=> done_out && phys_out == $past(req_in.phys))
    else $error("physical address not passed through");

  // global index above the limit is refused without a fetch
  chk_gdt_range: assert property ( // see RULE9
    @(posedge sys_clk_in) disable iff (!rstn_in)
    state == ST_IDLE && req_valid_in && in_needs_fetch && in_range_bad
    |=> done_out && fault_out == FLT_RANGE && !mem_req_out)
    else $error("global index range not enforced");

  // fetch address is base plus eight bytes per entry
  chk_fetch_addr: assert property ( // see RULE16 RULE11
    @(posedge sys_clk_in) disable iff (!rstn_in)
    $rose(mem_req_out)
    && (cur.cmd == CMD_LOAD_LDT || !cur.selector[SEL_TI_BIT])
    |-> mem_addr_out == gdt_base
        + {8'h00, cur.selector[SEL_W-1:SEL_IDX_LSB], 3'b000})
    else $error("descriptor fetch address wrong");

  // protected result is descriptor base plus offset
  chk_prot_sum: assert property ( // see RULE7 RULE8
    @(posedge sys_clk_in) disable iff (!rstn_in)
    state == ST_FETCH && mem_ack_in && cur.cmd == CMD_XLATE
    && !f_absent && !f_over
    |=> done_out && fault_out == FLT_NONE
        && phys_out == $past(f_sum) && dpl_out == $past(fd.access[6:5]))
    else $error("protected translation result wrong");

  // absent descriptor answers with a fault
  chk_present_bit: assert property ( // see RULE14 RULE15
    @(posedge sys_clk_in) disable iff (!rstn_in)
    state == ST_FETCH && mem_ack_in && !mem_data_in[47]
    |=> done_out && fault_out == FLT_ABSENT && !busy_out)
    else $error("absent segment not flagged");

  // fetched local table load fills selector and cache together
  chk_ldt_load: assert property ( // see RULE12
    @(posedge sys_clk_in) disable iff (!rstn_in)
    state == ST_FETCH && mem_ack_in && cur.cmd == CMD_LOAD_LDT && !f_absent
    |=> ldt_sel == $past(cur.selector) && ldt_cache == $past(fd))
    else $error("local table cache not loaded");

  // cached segment use never touches memory
  chk_seg_nofetch: assert property ( // see RULE13
    @(posedge sys_clk_in) disable iff (!rstn_in)
    state == ST_IDLE && req_valid_in && req_in.cmd == CMD_XLATE_SEG
    |=> done_out && !mem_req_out && !busy_out && state == ST_IDLE)
    else $error("segment use started a fetch");

endmodule
